// file: common/tlp_consts.vh
/*
 * Constants for the torque limit and position setpoint block: register byte
 * offsets, field positions, reset values, setting ranges and update timing.
 * Assumes a 20 MHz aclk and an AXI4-Lite register bus with 12 address bits.
 */
`ifndef TLP_CONSTS_VH
`define TLP_CONSTS_VH

`define TLP_A_CTRL 12'h000
`define TLP_A_SPD_LIM 12'h004
`define TLP_A_SPD_BIAS 12'h008
`define TLP_A_TLIM_POS 12'h00C
`define TLP_A_TLIM_NEG 12'h010
`define TLP_A_TLIM_FREG 12'h014
`define TLP_A_TLIM_RREG 12'h018
`define TLP_A_AI_GAIN 12'h01C
`define TLP_A_POS_FMAX 12'h020
`define TLP_A_PPR 12'h024
`define TLP_A_IDX_OFS 12'h028
`define TLP_A_FMIN 12'h02C
`define TLP_A_STATUS 12'h030
`define TLP_A_TARGET 12'h034
`define TLP_A_ORIGIN 12'h038
`define TLP_A_TABLE 12'h100
`define TLP_A_TABLE_END 12'h17C

`define TLP_CTRL_TMODE 0
`define TLP_CTRL_PSEL 1
`define TLP_CTRL_FN_LSB 8
`define TLP_CTRL_FN_MSB 12

`define TLP_FN_TLIM_POS 5'h0B
`define TLP_FN_TLIM_NEG 5'h0C
`define TLP_FN_TLIM_REGEN 5'h0D
`define TLP_FN_TLIM_BOTH 5'h0E
`define TLP_FN_TCOMP 5'h10

`define TLP_RST_SPD_LIM 16'h03E8
`define TLP_RST_SPD_BIAS 16'h0000
`define TLP_RST_TLIM 16'h07D0
`define TLP_RST_AI_GAIN 16'h03E8
`define TLP_RST_POS_FMAX 16'h01F4
`define TLP_RST_PPR 16'h0400
`define TLP_RST_FMIN 16'h0005

`define TLP_SPD_MAX 32'h000004B0
`define TLP_TLIM_MAX 32'h00000BB8
`define TLP_FMAX_MIN 32'h00000001
`define TLP_FMAX_MAX 32'h000003E8
`define TLP_SECT_MAX 32'h0000270F
`define TLP_GAIN_MAX 32'h00000BB8
`define TLP_AI_FS 12'h400
`define TLP_AI_SHIFT 10
`define TLP_DECEL1 2'h0

`define TLP_CLK_NS 50
`define TLP_UPDATE_NS 50000

`endif

// file: testbench/tlp_checker.sv
/*
 * Port checker for tlp_torque_pos: update pulse timing, command range,
 * register bus handshakes, position-mode outputs.
 * Assumes it is bound to the top module and sees only its ports.
 */
module tlp_checker (
	input wire aclk,
	input wire aresetn,
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire wready,
	input wire bvalid,
	input wire bready,
	input wire arvalid,
	input wire arready,
	input wire rvalid,
	input wire rready,
	input wire signed [15:0] torque_cmd,
	input wire torque_cmd_valid,
	input wire pos_mode_active,
	input wire [15:0] pos_freq_cap,
	input wire [1:0] decel_sel
);
	logic [10:0] gap;
	logic seen;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// the first update after reset has no known predecessor, so it is not timed
	always @(posedge aclk) begin
		if (!aresetn) begin
			gap <= 11'h000;
			seen <= 1'b0;
		end else if (torque_cmd_valid) begin
			gap <= 11'h000;
			seen <= 1'b1;
		end else begin
			gap <= gap + 11'h001;
		end
	end
	valid_pulse_a: assert property (torque_cmd_valid |=> !torque_cmd_valid)
		else $error("torque update pulse longer than one cycle");
	cmd_hold_a: assert property (!torque_cmd_valid |-> $stable(torque_cmd))
		else $error("torque command moved between updates");
	tick_gap_a: assert property (torque_cmd_valid && seen |-> gap == 11'h3E7)
		else $error("torque update period wrong");
	cmd_range_a: assert property (torque_cmd_valid |->
		torque_cmd >= -16'sh0BB8 && torque_cmd <= 16'sh0BB8)
		else $error("torque command beyond largest limit");
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response late");
	wr_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	wr_done_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write response not retired");
	rd_answer_a: assert property (arvalid && arready |-> ##[1:3] rvalid)
		else $error("read data late");
	cap_range_a: assert property (pos_freq_cap >= 16'h0001 && pos_freq_cap <= 16'h03E8)
		else $error("position frequency cap out of range");
	pos_decel_a: assert property (pos_mode_active && $past(pos_mode_active) |->
		decel_sel == 2'h0)
		else $error("position move not on first decel time");
endmodule // tlp_checker

bind tlp_torque_pos tlp_checker u_tlp_checker (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .torque_cmd(torque_cmd),
	.torque_cmd_valid(torque_cmd_valid), .pos_mode_active(pos_mode_active),
	.pos_freq_cap(pos_freq_cap), .decel_sel(decel_sel));

// file: testbench/tlp_motor_model.sv
/*
 * Motor and incremental encoder model: speed follows the set value, the
 * count steps once per 16 cycles while turning, index marks every 1024.
 * Assumes one aclk and a synchronous active-low reset.
 */
module tlp_motor_model (
	input wire aclk,
	input wire aresetn,
	input wire signed [15:0] speed_set,
	output logic signed [15:0] speed_fb,
	output logic signed [31:0] encoder_count,
	output wire encoder_index
);
	logic [3:0] div;
	// slow stepping keeps the index high long enough to be synchronised
	assign encoder_index = (encoder_count[9:0] == 10'h000);
	always @(posedge aclk) begin
		if (!aresetn) begin
			speed_fb <= 16'sh0000;
			encoder_count <= 32'sh000003F0;
			div <= 4'h0;
		end else begin
			speed_fb <= speed_set;
			div <= div + 4'h1;
			if (div == 4'hF && speed_set != 16'sh0000) begin
				encoder_count <= encoder_count + (speed_set[15] ? -32'sh1 : 32'sh1);
			end
		end
	end
endmodule // tlp_motor_model

// file: testbench/tlp_torque_pos_bench.sv
/*
 * Self-checking bench for tlp_torque_pos over its register bus.
 * Assumes the motor model on the far side and a 20 MHz aclk.
 */
`include "tlp_consts.vh"
module tlp_torque_pos_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic signed [15:0] spd = 16'sh0;
	logic signed [15:0] sreg = 16'sh0;
	logic signed [15:0] tref = 16'sh0;
	logic signed [11:0] ain = 12'sh0;
	logic [15:0] ofreq = 16'h0064;
	logic [1:0] dreq = 2'h0;
	logic [3:0] ssel = 4'h0;
	wire awready, wready, bvalid, arready, rvalid, tvalid, pact, ilock, eidx;
	wire [1:0] bresp, rresp, dsel;
	wire [31:0] rdata;
	wire [15:0] fcap;
	wire signed [15:0] tcmd, sfb;
	wire signed [23:0] ptgt;
	wire signed [31:0] porg, enc;
	int failures = 0;
	int checks_done = 0;

	always #25 aclk = ~aclk;

	tlp_torque_pos u_tlp_torque_pos (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .speed_fb(sfb), .speed_reg_out(sreg),
		.torque_ref(tref), .second_analog_input(ain), .output_freq(ofreq),
		.encoder_count(enc), .decel_req(dreq), .encoder_index(eidx), .section_sel(ssel),
		.torque_cmd(tcmd), .torque_cmd_valid(tvalid), .pos_target(ptgt), .pos_origin(porg),
		.pos_mode_active(pact), .index_locked(ilock), .pos_freq_cap(fcap), .decel_sel(dsel));
	tlp_motor_model u_tlp_motor_model (.aclk(aclk), .aresetn(aresetn), .speed_set(spd),
		.speed_fb(sfb), .encoder_count(enc), .encoder_index(eidx));

	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic bound(input int n, input int m);
		if (n >= m) begin
			failures++;
			$display("wrong value wait bound expected %0d seen %0d", m - 1, n);
			print_verdict;
		end
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input [11:0] a, input [31:0] d, input [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bound(n, 50);
		chk("bresp", er, bresp);
	endtask

	task automatic rdc(input [11:0] a, input [31:0] e, input [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		bound(n, 50);
		chk("rdata", e, rdata);
		chk("rresp", er, rresp);
	endtask

	// two updates, so the second surely saw the new inputs
	task automatic tick;
		int n;
		int c;
		c = 0;
		for (n = 0; n < 2200 && c < 2; n++) begin
			@(posedge aclk);
			if (tvalid === 1'b1) c++;
		end
		bound(n, 2200);
	endtask

	task automatic tq(input [31:0] c, input int s, input int r, input int a, input int e);
		wr(`TLP_A_CTRL, c, 2'h0);
		spd <= 16'(s);
		// the source not in use gets the opposite sign, so a wrong pick shows
		tref <= c[0] ? 16'(r) : -16'(r);
		sreg <= c[0] ? -16'(r) : 16'(r);
		ain <= 12'(a);
		tick;
		chk("torque_cmd", e, tcmd);
	endtask

	initial begin
		int n;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`TLP_A_CTRL, 0, 2'h0);
		rdc(`TLP_A_SPD_LIM, 1000, 2'h0);
		rdc(`TLP_A_TLIM_RREG, 2000, 2'h0);
		rdc(`TLP_A_AI_GAIN, 1000, 2'h0);
		rdc(`TLP_A_POS_FMAX, 500, 2'h0);
		rdc(`TLP_A_PPR, 1024, 2'h0);
		rdc(12'h040, 0, 2'h2);
		wr(12'h040, 32'h5, 2'h2);
		wr(`TLP_A_STATUS, 32'hFFFFFFFF, 2'h0);
		wr(`TLP_A_TLIM_POS, 4000, 2'h0);
		rdc(`TLP_A_TLIM_POS, 3000, 2'h0);
		wr(`TLP_A_TLIM_POS, 2000, 2'h0);
		wr(`TLP_A_POS_FMAX, 0, 2'h0);
		rdc(`TLP_A_POS_FMAX, 1, 2'h0);
		wr(`TLP_A_POS_FMAX, 2000, 2'h0);
		rdc(`TLP_A_POS_FMAX, 1000, 2'h0);
		chk("pos_freq_cap", 1000, fcap);
		wr(12'h178, 32'hFFFFD120, 2'h0);
		rdc(12'h178, 32'hFFFFD8F1, 2'h0);
		wstrb <= 4'h1;
		wr(`TLP_A_IDX_OFS, 32'hFFFFFF64, 2'h0);
		wstrb <= 4'hF;
		rdc(`TLP_A_IDX_OFS, 100, 2'h0);
		wr(`TLP_A_TLIM_NEG, 1500, 2'h0);
		wr(`TLP_A_TLIM_FREG, 1200, 2'h0);
		wr(`TLP_A_TLIM_RREG, 900, 2'h0);
		wr(`TLP_A_SPD_BIAS, 200, 2'h0);
		tq(32'h1, 1300, 500, 0, -900);
		rdc(`TLP_A_STATUS, 32'h74, 2'h0);
		tq(32'h1, -300, -500, 0, 1500);
		tq(32'h1, 1150, 500, 0, 500);
		tq(32'h1, -150, -2500, 0, -1200);
		tq(32'h1, 100, 2500, 0, 2000);
		tq(32'hE00, 100, 2500, 512, 500);
		tq(32'hC00, 100, 2500, 512, 2000);
		tq(32'hC00, 100, -2500, 512, -500);
		tq(32'hB00, 100, 2500, 512, 500);
		tq(32'hD00, -100, 2500, 512, 500);
		tq(32'hE00, 100, 2500, 1024, 1000);
		tq(32'h1000, -100, 100, -512, -400);
		wr(`TLP_A_AI_GAIN, 2000, 2'h0);
		tq(32'hE00, 100, 2500, 1024, 2000);
		tq(32'h1000, 100, 2500, 512, 2000);
		wr(12'h118, 32'h2, 2'h0);
		wr(12'h11C, 32'hFFFFFFFB, 2'h0);
		ssel <= 4'h3;
		tick;
		chk("pos_target", 2043, ptgt);
		rdc(`TLP_A_TARGET, 2043, 2'h0);
		wr(`TLP_A_PPR, 32'hFFFF, 2'h0);
		wr(12'h120, 32'h270F, 2'h0);
		wr(12'h124, 32'h270F, 2'h0);
		ssel <= 4'h4;
		tick;
		chk("pos_target", 32'h007FFFFF, ptgt);
		wr(`TLP_A_CTRL, 32'h0, 2'h0);
		spd <= 16'sh0;
		dreq <= 2'h2;
		repeat (4) @(posedge aclk);
		ofreq <= 16'h0003;
		for (n = 0; n < 100 && pact !== 1'b1; n++) @(posedge aclk);
		bound(n, 100);
		chk("pos_origin", enc, porg);
		@(posedge aclk);
		chk("decel_sel", 2'h0, dsel);
		ofreq <= 16'h0064;
		for (n = 0; n < 100 && pact !== 1'b0; n++) @(posedge aclk);
		bound(n, 100);
		repeat (3) @(posedge aclk);
		chk("decel_sel", 2'h2, dsel);
		wr(`TLP_A_CTRL, 32'h2, 2'h0);
		spd <= 16'sh0032;
		ofreq <= 16'h0003;
		for (n = 0; n < 20000 && ilock !== 1'b1; n++) @(posedge aclk);
		bound(n, 20000);
		chk("pos_origin", enc + 100, porg);
		rdc(`TLP_A_ORIGIN, enc + 100, 2'h0);
		print_verdict;
	end
endmodule // tlp_torque_pos_bench

// file: verilog/tlp_pos_calc.v
/*
 * Section target calculator: rotations times encoder pulses per revolution
 * plus pulses, saturated to 24 bits and registered on the update enable.
 * Assumes its inputs are stable in the cycle where en is high.
 */
module tlp_pos_calc (
	input wire aclk,
	input wire aresetn,
	input wire en,
	input wire signed [15:0] rev,
	input wire signed [15:0] pls,
	input wire [15:0] ppr,
	output reg signed [23:0] target
);
	wire signed [32:0] prod;
	wire signed [33:0] sum;

	assign prod = rev * $signed({1'b0, ppr});
	assign sum = {prod[32], prod} + {{18{pls[15]}}, pls};

	always @(posedge aclk) begin
		if (!aresetn) begin
			target <= 24'sh000000;
		end else if (en) begin
			if (sum > $signed(34'sh00007FFFFF))
				target <= 24'sh7FFFFF;
			else if (sum < $signed(-34'sh00007FFFFF))
				target <= -24'sh7FFFFF;
			else
				target <= sum[23:0];
		end
	end
endmodule // tlp_pos_calc

// file: verilog/tlp_torque_pos.v
/*
 * Torque supervisor and position setpoint table of a motor drive, with an
 * AXI4-Lite register slave. Assumes speed, torque, analog and encoder count
 * inputs come from logic on aclk; index and section select are pins.
 */
// Function
// - torque mode keeps speed between minus bias and limit plus bias
// - speed above upper boundary forces negative torque over the reference
// - speed below minus bias forces forward torque
// - compensation sign follows analog input polarity, not run direction
// - positive compensation input gives positive compensation torque
// - four torque limit settings, each 0 to 300 percent
// - limits map to quadrants: positive, negative, forward regen, reverse regen; code: second for negative, third forward regen, fourth reverse regen
// - torque limit overrides speed regulation and compensation
// - limits come from fixed settings or the analog input
// - analog function codes 11, 12, 13, 14 select limit kinds
// - code 12 applies analog limit in third and fourth quadrants
// - code 13 applies analog limit in second and fourth quadrants
// - code 14 applies analog limit in all quadrants
// - full-scale analog equals rated torque, scaled by gain
// - default span maps zero to full scale onto 0 to 100 percent
// - position move frequency capped at 0.1 to 100 Hz setting
// - sixteen sections of rotations and pulses, each within plus minus 9999
// - mode 0 enters position below minimum frequency, mode 1 index locked
// - target equals rotations times pulses per revolution plus pulses
// - index-locked origin is index position plus offset
// - speed bias is a percentage of maximum output frequency
// - position moves use the first deceleration time
`include "tlp_consts.vh"
module tlp_torque_pos (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] awaddr,
	input wire [2:0] awprot,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [11:0] araddr,
	input wire [2:0] arprot,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire signed [15:0] speed_fb,
	input wire signed [15:0] speed_reg_out,
	input wire signed [15:0] torque_ref,
	input wire signed [11:0] second_analog_input,
	input wire [15:0] output_freq,
	input wire signed [31:0] encoder_count,
	input wire [1:0] decel_req,
	input wire encoder_index,
	input wire [3:0] section_sel,
	output reg signed [15:0] torque_cmd,
	output reg torque_cmd_valid,
	output reg signed [23:0] pos_target,
	output reg signed [31:0] pos_origin,
	output reg pos_mode_active,
	output reg index_locked,
	output reg [15:0] pos_freq_cap,
	output reg [1:0] decel_sel
);
	localparam [31:0] UPD_CYCLES = `TLP_UPDATE_NS / `TLP_CLK_NS;
	localparam [9:0] UPD_LAST = UPD_CYCLES[9:0] - 10'h001;

	reg torque_mode;
	reg pos_sel;
	reg [4:0] ai_fn;
	reg signed [15:0] spd_lim;
	reg [15:0] spd_bias;
	reg [15:0] tlim [0:3];
	reg [15:0] ai_gain;
	reg [15:0] pos_fmax;
	reg [15:0] ppr;
	reg [15:0] idx_ofs;
	reg [15:0] fmin;
	reg signed [15:0] sect_rev [0:15];
	reg signed [15:0] sect_pls [0:15];
	reg band_high;
	reg band_low;
	reg clamp_hit;
	reg [1:0] quad_q;
	reg [9:0] div_cnt;
	reg tick;
	reg [1:0] idx_sync;
	reg idx_prev;
	reg [3:0] sel_s1;
	reg [3:0] sel_s2;
	reg aw_held;
	reg w_held;
	reg ar_held;
	reg [11:0] aw_addr_q;
	reg [11:0] ar_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [31:0] mux_word;
	reg mux_hit;
	reg signed [19:0] demand;
	reg [1:0] quad;
	reg use_ai;
	reg [16:0] lim_q;
	reg signed [19:0] clamped;
	wire signed [23:0] sect_target;
	wire wr_en;
	wire [11:0] mux_addr;
	wire signed [31:0] wmerged;
	wire [11:0] ai_mag;
	wire [27:0] ai_prod;
	wire [15:0] ai_lim;
	wire signed [28:0] comp_prod;
	wire signed [18:0] comp;
	wire signed [17:0] upper;
	wire signed [17:0] lower;
	wire freq_low;
	wire idx_edge;
	integer i;

	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] st;
		integer b;
		begin
			wmerge = old;
			for (b = 0; b < 4; b = b + 1)
				if (st[b])
					wmerge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	function [15:0] sat;
		input signed [31:0] v;
		input signed [31:0] lo;
		input signed [31:0] hi;
		begin
			if (v < lo)
				sat = lo[15:0];
			else if (v > hi)
				sat = hi[15:0];
			else
				sat = v[15:0];
		end
	endfunction

	assign wr_en = aw_held & w_held & ~bvalid;
	assign mux_addr = wr_en ? {aw_addr_q[11:2], 2'b00} : {ar_addr_q[11:2], 2'b00};
	assign wmerged = wmerge(mux_word, w_data_q, w_strb_q);

	always @* begin
		mux_word = 32'h00000000;
		mux_hit = 1'b1;
		if (mux_addr >= `TLP_A_TABLE && mux_addr <= `TLP_A_TABLE_END) begin
			if (mux_addr[2])
				mux_word = {{16{sect_pls[mux_addr[6:3]][15]}}, sect_pls[mux_addr[6:3]]};
			else
				mux_word = {{16{sect_rev[mux_addr[6:3]][15]}}, sect_rev[mux_addr[6:3]]};
		end else begin
			case (mux_addr)
				`TLP_A_CTRL: mux_word = {19'h00000, ai_fn, 6'h00, pos_sel, torque_mode};
				`TLP_A_SPD_LIM: mux_word = {{16{spd_lim[15]}}, spd_lim};
				`TLP_A_SPD_BIAS: mux_word = {16'h0000, spd_bias};
				`TLP_A_TLIM_POS: mux_word = {16'h0000, tlim[0]};
				`TLP_A_TLIM_NEG: mux_word = {16'h0000, tlim[1]};
				`TLP_A_TLIM_FREG: mux_word = {16'h0000, tlim[2]};
				`TLP_A_TLIM_RREG: mux_word = {16'h0000, tlim[3]};
				`TLP_A_AI_GAIN: mux_word = {16'h0000, ai_gain};
				`TLP_A_POS_FMAX: mux_word = {16'h0000, pos_fmax};
				`TLP_A_PPR: mux_word = {16'h0000, ppr};
				`TLP_A_IDX_OFS: mux_word = {16'h0000, idx_ofs};
				`TLP_A_FMIN: mux_word = {16'h0000, fmin};
				`TLP_A_STATUS: mux_word = {25'h0000000, quad_q, clamp_hit, band_low,
					band_high, index_locked, pos_mode_active};
				`TLP_A_TARGET: mux_word = {{8{pos_target[23]}}, pos_target};
				`TLP_A_ORIGIN: mux_word = pos_origin;
				default: mux_hit = 1'b0;
			endcase
		end
	end

	// bus handshakes: one write and one read at a time, write wins a tie
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			arready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= 2'b00;
			rvalid <= 1'b0;
			rresp <= 2'b00;
			rdata <= 32'h00000000;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			ar_held <= 1'b0;
			aw_addr_q <= 12'h000;
			ar_addr_q <= 12'h000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				wready <= 1'b0;
			end
			if (wr_en) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= mux_hit ? 2'b00 : 2'b10;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
			if (arvalid && arready) begin
				ar_held <= 1'b1;
				ar_addr_q <= araddr;
				arready <= 1'b0;
			end
			if (ar_held && !wr_en && !rvalid) begin
				ar_held <= 1'b0;
				rvalid <= 1'b1;
				rdata <= mux_word;
				rresp <= mux_hit ? 2'b00 : 2'b10;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// settings except ppr and fmin clamp to their ranges on write; read-only words ignore writes
	always @(posedge aclk) begin
		if (!aresetn) begin
			torque_mode <= 1'b0;
			pos_sel <= 1'b0;
			ai_fn <= 5'h00;
			spd_lim <= `TLP_RST_SPD_LIM;
			spd_bias <= `TLP_RST_SPD_BIAS;
			ai_gain <= `TLP_RST_AI_GAIN;
			pos_fmax <= `TLP_RST_POS_FMAX;
			ppr <= `TLP_RST_PPR;
			idx_ofs <= 16'h0000;
			fmin <= `TLP_RST_FMIN;
			for (i = 0; i < 4; i = i + 1)
				tlim[i] <= `TLP_RST_TLIM;
			for (i = 0; i < 16; i = i + 1) begin
				sect_rev[i] <= 16'h0000;
				sect_pls[i] <= 16'h0000;
			end
		end else if (wr_en) begin
			if (aw_addr_q >= `TLP_A_TABLE && aw_addr_q <= `TLP_A_TABLE_END) begin
				if (aw_addr_q[2])
					sect_pls[aw_addr_q[6:3]] <= sat(wmerged, -$signed(`TLP_SECT_MAX),
						$signed(`TLP_SECT_MAX));
				else
					sect_rev[aw_addr_q[6:3]] <= sat(wmerged, -$signed(`TLP_SECT_MAX),
						$signed(`TLP_SECT_MAX));
			end else begin
				case ({aw_addr_q[11:2], 2'b00})
					`TLP_A_CTRL: begin
						torque_mode <= wmerged[`TLP_CTRL_TMODE];
						pos_sel <= wmerged[`TLP_CTRL_PSEL];
						ai_fn <= wmerged[`TLP_CTRL_FN_MSB:`TLP_CTRL_FN_LSB];
					end
					`TLP_A_SPD_LIM: spd_lim <= sat(wmerged, -$signed(`TLP_SPD_MAX),
						$signed(`TLP_SPD_MAX));
					`TLP_A_SPD_BIAS: spd_bias <= sat(wmerged, 32'sd0, $signed(`TLP_SPD_MAX));
					`TLP_A_TLIM_POS: tlim[0] <= sat(wmerged, 32'sd0, $signed(`TLP_TLIM_MAX));
					`TLP_A_TLIM_NEG: tlim[1] <= sat(wmerged, 32'sd0, $signed(`TLP_TLIM_MAX));
					`TLP_A_TLIM_FREG: tlim[2] <= sat(wmerged, 32'sd0, $signed(`TLP_TLIM_MAX));
					`TLP_A_TLIM_RREG: tlim[3] <= sat(wmerged, 32'sd0, $signed(`TLP_TLIM_MAX));
					`TLP_A_AI_GAIN: ai_gain <= sat(wmerged, 32'sd0, $signed(`TLP_GAIN_MAX));
					// cap within 0.1 to 100 Hz
					`TLP_A_POS_FMAX: pos_fmax <= sat(wmerged, $signed(`TLP_FMAX_MIN),
						$signed(`TLP_FMAX_MAX));
					`TLP_A_PPR: ppr <= wmerged[15:0];
					`TLP_A_IDX_OFS: idx_ofs <= sat(wmerged, 32'sd0, $signed(`TLP_SECT_MAX));
					`TLP_A_FMIN: fmin <= wmerged[15:0];
					default: ;
				endcase
			end
		end
	end

	// update pacing and pin synchronisers
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 10'h000;
			tick <= 1'b0;
			idx_sync <= 2'b00;
			idx_prev <= 1'b0;
			sel_s1 <= 4'h0;
			sel_s2 <= 4'h0;
		end else begin
			tick <= (div_cnt == UPD_LAST);
			div_cnt <= (div_cnt == UPD_LAST) ? 10'h000 : div_cnt + 10'h001;
			idx_sync <= {idx_sync[0], encoder_index};
			idx_prev <= idx_sync[1];
			sel_s1 <= section_sel;
			sel_s2 <= sel_s1;
		end
	end

	// full scale times gain gives the limit
	// span maps onto 0 to 100 percent at unity gain
	assign ai_mag = second_analog_input[11] ? 12'h000 :
		((second_analog_input > $signed({1'b0, `TLP_AI_FS})) ? `TLP_AI_FS :
		second_analog_input);
	assign ai_prod = ai_mag * ai_gain;
	assign ai_lim = ai_prod[25:10];
	assign comp_prod = second_analog_input * $signed({1'b0, ai_gain});
	assign comp = (ai_fn == `TLP_FN_TCOMP) ? comp_prod[28:`TLP_AI_SHIFT] : 19'sh00000;
	// speed and bias share units of maximum output frequency
	assign upper = spd_lim + $signed({2'b00, spd_bias});
	assign lower = -$signed({2'b00, spd_bias});

	always @* begin
		// band from minus bias to limit plus bias
		if (torque_mode && (speed_fb > upper))
			demand = -20'sh7FFFF;
		else if (torque_mode && (speed_fb < lower))
			demand = 20'sh7FFFF;
		else if (torque_mode)
			demand = torque_ref + comp;
		else
			demand = speed_reg_out + comp;
		// quadrant from speed and torque sign
		quad = {demand[19], demand[19] ^ speed_fb[15]};
		case (ai_fn)
			`TLP_FN_TLIM_POS: use_ai = (quad == 2'd0);
			`TLP_FN_TLIM_NEG: use_ai = quad[1];
			`TLP_FN_TLIM_REGEN: use_ai = quad[0];
			`TLP_FN_TLIM_BOTH: use_ai = 1'b1;
			default: use_ai = 1'b0;
		endcase
		lim_q = use_ai ? {1'b0, ai_lim} : {1'b0, tlim[quad]};
		// limit wins over regulation and compensation
		if (demand > $signed({3'b000, lim_q}))
			clamped = $signed({3'b000, lim_q});
		else if (demand < -$signed({3'b000, lim_q}))
			clamped = -$signed({3'b000, lim_q});
		else
			clamped = demand;
	end

	assign freq_low = output_freq < fmin;
	assign idx_edge = idx_sync[1] & ~idx_prev;

	tlp_pos_calc u_pos_calc (
		.aclk(aclk),
		.aresetn(aresetn),
		.en(tick),
		.rev(sect_rev[sel_s2]),
		.pls(sect_pls[sel_s2]),
		.ppr(ppr),
		.target(sect_target)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			torque_cmd <= 16'sh0000;
			torque_cmd_valid <= 1'b0;
			band_high <= 1'b0;
			band_low <= 1'b0;
			clamp_hit <= 1'b0;
			quad_q <= 2'b00;
			pos_target <= 24'sh000000;
			pos_origin <= 32'sh00000000;
			pos_mode_active <= 1'b0;
			index_locked <= 1'b0;
			pos_freq_cap <= `TLP_RST_POS_FMAX;
			decel_sel <= `TLP_DECEL1;
		end else begin
			torque_cmd_valid <= tick;
			pos_target <= sect_target;
			pos_freq_cap <= pos_fmax;
			// first deceleration time in position moves
			decel_sel <= pos_mode_active ? `TLP_DECEL1 : decel_req;
			if (tick) begin
				torque_cmd <= sat({{12{clamped[19]}}, clamped}, -32'sd32767, 32'sd32767);
				band_high <= torque_mode && (speed_fb > upper);
				band_low <= torque_mode && (speed_fb < lower);
				clamp_hit <= (clamped != demand);
				quad_q <= quad;
			end
			// mode 0 below minimum frequency, mode 1 needs index
			if (!freq_low || !pos_sel)
				index_locked <= 1'b0;
			if (pos_sel && freq_low && idx_edge && !index_locked) begin
				index_locked <= 1'b1;
				pos_origin <= encoder_count + $signed({16'h0000, idx_ofs});
			end
			if (!pos_sel)
				pos_mode_active <= freq_low;
			else
				pos_mode_active <= freq_low & index_locked;
			if (!pos_sel && freq_low && !pos_mode_active)
				pos_origin <= encoder_count;
		end
	end
endmodule // tlp_torque_pos
